// ==== core/tlb_store.sv ====
// translation cache storage, registered read
`timescale 1ns/1ps
`include "xlate_consts.svh"

module tlb_store (
  input wire logic clk,
  input wire logic writeEn,
  input wire logic [`TLB_IDX_BITS-1:0] writeIdx,
  input xlate_pkg::tlb_entry_t writeData,
  input wire logic [`TLB_IDX_BITS-1:0] readIdx,
  output xlate_pkg::tlb_entry_t readData
);
  xlate_pkg::tlb_entry_t mem [0:`TLB_DEPTH-1];

  always_ff @(posedge clk) begin
    if (writeEn) begin
      mem[writeIdx] <= writeData;
    end
    readData <= mem[readIdx];
  end
endmodule // tlb_store

// ==== core/vaddr_translator.sv ====
// virtual to physical address translator with a direct-mapped cache
`timescale 1ns/1ps
`include "xlate_consts.svh"

module vaddr_translator (
  input wire logic clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [3:0] regSel,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic reqValid,
  input wire logic [31:0] reqVaddr,
  output logic reqReady,
  output logic respValid,
  output xlate_pkg::xlate_resp_t resp,
  output logic memReq,
  output logic [29:0] memAddr,
  input wire logic memAck,
  input wire logic [31:0] memData
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic translation_enable_reg;
  logic [31:0] sysBase_reg;
  logic [21:0] sysLen_reg;
  logic [31:0] lowBase_reg;
  logic [21:0] lowLen_reg;
  logic [31:0] highBase_reg;
  logic [21:0] highLen_reg;
  logic [`TLB_DEPTH-1:0] tlbValid_reg;
  xlate_pkg::walk_state_t state_reg;
  logic [31:0] vaddr_reg;
  logic [31:0] pteVa_reg;
  xlate_pkg::tlb_entry_t tlbRead;
  logic tlbFill;
  xlate_pkg::tlb_entry_t tlbFillData;
  logic dropOne;
  logic dropAll;

  assign dropOne = regWrite && regSel == `SEL_DROP_ONE;
  assign dropAll = regWrite && regSel == `SEL_DROP_ALL;

  always_ff @(posedge clk) begin
    if (reset) begin
      translation_enable_reg <= `RESET_ENABLE;
      sysBase_reg <= `RESET_BASE;
      sysLen_reg <= `RESET_LEN;
      lowBase_reg <= `RESET_BASE;
      lowLen_reg <= `RESET_LEN;
      highBase_reg <= `RESET_BASE;
      highLen_reg <= `RESET_LEN;
    end else if (regWrite) begin
      unique case (regSel)
        `SEL_ENABLE: translation_enable_reg <= regWdata[`ENABLE_BIT];
        `SEL_SYS_BASE: sysBase_reg <= regWdata;
        `SEL_SYS_LEN: sysLen_reg <= regWdata[21:0];
        `SEL_LOW_BASE: lowBase_reg <= regWdata;
        `SEL_LOW_LEN: lowLen_reg <= regWdata[21:0];
        `SEL_HIGH_BASE: highBase_reg <= regWdata;
        `SEL_HIGH_LEN: highLen_reg <= regWdata[21:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regRdata <= 32'h00000000;
    end else begin
      unique case (regSel)
        `SEL_ENABLE: regRdata <= {31'h00000000, translation_enable_reg};
        `SEL_SYS_BASE: regRdata <= sysBase_reg;
        `SEL_SYS_LEN: regRdata <= {10'h000, sysLen_reg};
        `SEL_LOW_BASE: regRdata <= lowBase_reg;
        `SEL_LOW_LEN: regRdata <= {10'h000, lowLen_reg};
        `SEL_HIGH_BASE: regRdata <= highBase_reg;
        `SEL_HIGH_LEN: regRdata <= {10'h000, highLen_reg};
        default: regRdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // translation cache
  // ---------------------------------------------------------------
  tlb_store store (
    .clk(clk),
    .writeEn(tlbFill),
    .writeIdx(vaddr_reg[12:9]),
    .writeData(tlbFillData),
    .readIdx(reqVaddr[12:9]),
    .readData(tlbRead)
  );

  logic [`TLB_DEPTH-1:0] fillMask;
  for (genvar g = 0; g < `TLB_DEPTH; g++) begin : g_fill
    assign fillMask[g] = tlbFill && vaddr_reg[12:9] == 4'(g);
  end

  // a fill landing in the same cycle as a drop keeps its slot valid
  always_ff @(posedge clk) begin
    if (reset) begin
      tlbValid_reg <= '0;
    end else begin
      for (int i = 0; i < `TLB_DEPTH; i++) begin
        if (fillMask[i]) begin
          tlbValid_reg[i] <= 1'b1;
        end else if (dropAll) begin
          tlbValid_reg[i] <= 1'b0;
        end else if (dropOne && regWdata[12:9] == 4'(i)) begin
          tlbValid_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // walk
  // ---------------------------------------------------------------
  logic [1:0] region;
  logic [20:0] vpn;
  logic lenFault;
  logic hit;
  logic [31:0] pteVa;
  logic [20:0] sysVpn;
  logic sysFault;
  xlate_pkg::pte_t fetched;

  assign region = vaddr_reg[31:30];
  assign vpn = vaddr_reg[29:`PAGE_BITS];
  assign fetched = xlate_pkg::pte_t'(memData);

  always_comb begin
    unique case (region)
      `REGION_SYS: lenFault = {1'b0, vpn} >= sysLen_reg;
      `REGION_LOW: lenFault = {1'b0, vpn} >= lowLen_reg;
      `REGION_HIGH: lenFault = {1'b0, vpn} < highLen_reg;
      default: lenFault = 1'b1;
    endcase
  end

  assign hit = tlbValid_reg[vaddr_reg[12:9]] && tlbRead.tag == vaddr_reg[31:13];
  assign pteVa = (region == `REGION_LOW ? lowBase_reg : highBase_reg)
    + {9'h000, vpn, 2'h0};
  assign sysVpn = pteVa[29:`PAGE_BITS];
  assign sysFault = pteVa[31:30] != `REGION_SYS || {1'b0, sysVpn} >= sysLen_reg;
  assign tlbFill = state_reg == xlate_pkg::S_FETCH_PTE && memAck && fetched.valid;
  assign tlbFillData = '{tag: vaddr_reg[31:13], page_table_entry: fetched};
  assign reqReady = state_reg == xlate_pkg::S_IDLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= xlate_pkg::S_IDLE;
      vaddr_reg <= 32'h00000000;
      pteVa_reg <= 32'h00000000;
      memReq <= 1'b0;
      memAddr <= 30'h00000000;
      respValid <= 1'b0;
      resp <= '0;
    end else begin
      respValid <= 1'b0;
      unique case (state_reg)
        xlate_pkg::S_IDLE: begin
          if (reqValid) begin
            vaddr_reg <= reqVaddr;
            state_reg <= xlate_pkg::S_CHECK;
          end
        end
        xlate_pkg::S_CHECK: begin
          if (!translation_enable_reg) begin
            respValid <= 1'b1;
            resp <= '{fault: 1'b0, rights: 4'h0, modify: 1'b0,
              paddr: vaddr_reg[29:0]};
            state_reg <= xlate_pkg::S_IDLE;
          end else if (lenFault) begin
            respValid <= 1'b1;
            resp <= '{fault: 1'b1, rights: 4'h0, modify: 1'b0, paddr: 30'h00000000};
            state_reg <= xlate_pkg::S_IDLE;
          end else if (hit) begin
            respValid <= 1'b1;
            resp <= '{fault: 1'b0, rights: tlbRead.page_table_entry.rights, modify: tlbRead.page_table_entry.modify,
              paddr: {tlbRead.page_table_entry.frame, vaddr_reg[8:0]}};
            state_reg <= xlate_pkg::S_IDLE;
          end else if (region == `REGION_SYS) begin
            memReq <= 1'b1;
            memAddr <= sysBase_reg[29:0] + {7'h00, vpn, 2'h0};
            state_reg <= xlate_pkg::S_FETCH_PTE;
          end else if (sysFault) begin
            respValid <= 1'b1;
            resp <= '{fault: 1'b1, rights: 4'h0, modify: 1'b0, paddr: 30'h00000000};
            state_reg <= xlate_pkg::S_IDLE;
          end else begin
            pteVa_reg <= pteVa;
            memReq <= 1'b1;
            memAddr <= sysBase_reg[29:0] + {7'h00, sysVpn, 2'h0};
            state_reg <= xlate_pkg::S_FETCH_SYS;
          end
        end
        xlate_pkg::S_FETCH_SYS: begin
          if (memAck) begin
            if (!fetched.valid) begin
              memReq <= 1'b0;
              respValid <= 1'b1;
              resp <= '{fault: 1'b1, rights: 4'h0, modify: 1'b0,
                paddr: 30'h00000000};
              state_reg <= xlate_pkg::S_IDLE;
            end else begin
              memAddr <= {fetched.frame, pteVa_reg[8:0]};
              state_reg <= xlate_pkg::S_FETCH_PTE;
            end
          end
        end
        xlate_pkg::S_FETCH_PTE: begin
          if (memAck) begin
            memReq <= 1'b0;
            respValid <= 1'b1;
            if (!fetched.valid) begin
              resp <= '{fault: 1'b1, rights: 4'h0, modify: 1'b0,
                paddr: 30'h00000000};
            end else begin
              resp <= '{fault: 1'b0, rights: fetched.rights, modify: fetched.modify,
                paddr: {fetched.frame, vaddr_reg[8:0]}};
            end
            state_reg <= xlate_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic inCheck;
  assign inCheck = state_reg == xlate_pkg::S_CHECK && translation_enable_reg;

  sequence faultOut;
    respValid && resp.fault;
  endsequence

  sequence fetchStarted;
    memReq && state_reg == xlate_pkg::S_FETCH_PTE;
  endsequence

  a_region_three: assert property (inCheck && region == 2'h3 |=> faultOut)
    else $error("reserved region did not fault");
  a_pass_through: assert property (state_reg == xlate_pkg::S_CHECK
    && !translation_enable_reg |=> respValid && !resp.fault
    && resp.paddr == $past(vaddr_reg[29:0]))
    else $error("disabled mapping did not pass address");
  a_offset_kept: assert property (respValid && !resp.fault
    && translation_enable_reg |-> resp.paddr[8:0] == vaddr_reg[8:0])
    else $error("byte offset changed");
  a_sys_length: assert property (inCheck && region == 2'h2
    && {1'b0, vpn} >= sysLen_reg |=> faultOut)
    else $error("system length overrun not faulted");
  a_high_length: assert property (inCheck && region == 2'h1
    && {1'b0, vpn} < highLen_reg |=> faultOut)
    else $error("high region hole not faulted");
  a_sys_fetch: assert property (inCheck && region == 2'h2 && !lenFault && !hit
    |=> fetchStarted and memAddr == $past(sysBase_reg[29:0]) + {7'h00, $past(vpn), 2'h0})
    else $error("system entry address wrong");
  a_drop_all: assert property (dropAll |=> (tlbValid_reg & ~$past(fillMask)) == '0)
    else $error("flush-all left entries");
  a_drop_one: assert property (dropOne
    |=> !tlbValid_reg[$past(regWdata[12:9])] || $past(fillMask[regWdata[12:9]]))
    else $error("single drop left entry");
  a_invalid_pte: assert property (state_reg == xlate_pkg::S_FETCH_PTE
    && memAck && !memData[31] |=> faultOut ##1 !respValid)
    else $error("invalid entry not faulted");
endmodule // vaddr_translator

// ==== core/xlate_consts.svh ====
// constants for the virtual address translator
`ifndef XLATE_CONSTS_SVH
`define XLATE_CONSTS_SVH

// ---------------------------------------------------------------
// processor register selectors
// ---------------------------------------------------------------
`define SEL_ENABLE 4'h0
`define SEL_DROP_ONE 4'h1
`define SEL_DROP_ALL 4'h2
`define SEL_SYS_BASE 4'h3
`define SEL_SYS_LEN 4'h4
`define SEL_LOW_BASE 4'h5
`define SEL_LOW_LEN 4'h6
`define SEL_HIGH_BASE 4'h7
`define SEL_HIGH_LEN 4'h8

// ---------------------------------------------------------------
// field positions and codes
// ---------------------------------------------------------------
`define ENABLE_BIT 0
`define REGION_LOW 2'h0
`define REGION_HIGH 2'h1
`define REGION_SYS 2'h2
`define PAGE_BITS 9
`define TLB_IDX_BITS 4
`define TLB_DEPTH 16

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RESET_ENABLE 1'h0
`define RESET_BASE 32'h00000000
`define RESET_LEN 22'h000000

`endif

// ==== core/xlate_pkg.sv ====
// types shared by the virtual address translator
package xlate_pkg;

  // page table entry layout
  typedef struct packed {
    logic valid;
    logic [3:0] rights;
    logic modify;
    logic [4:0] owner;
    logic [20:0] frame;
  } pte_t;

  typedef struct packed {
    logic [18:0] tag;
    pte_t page_table_entry;
  } tlb_entry_t;

  typedef struct packed {
    logic fault;
    logic [3:0] rights;
    logic modify;
    logic [29:0] paddr;
  } xlate_resp_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_CHECK = 4'h2,
    S_FETCH_SYS = 4'h4,
    S_FETCH_PTE = 4'h8
  } walk_state_t;

endpackage

// ==== tb/page_mem.sv ====
// page table memory behind the translator's fetch port
`timescale 1ns/1ps

module page_mem (
  input wire logic clk,
  input wire logic slow,
  input wire logic memReq,
  input wire logic [29:0] memAddr,
  output logic memAck,
  output logic [31:0] memData
);
  logic [31:0] mem [logic [29:0]];
  int cnt;
  initial begin
    memAck = 1'b0;
    memData = 32'h0;
    cnt = 0;
  end
  // answer after 0 or 5 wait cycles; data lines scramble while no request is pending and after each ack, and hold during wait cycles
  always @(posedge clk) begin
    if (memAck || !memReq) begin
      memAck <= 1'b0;
      memData <= ~memData;
      cnt <= 0;
    end else if (cnt >= (slow ? 5 : 0)) begin
      memAck <= 1'b1;
      memData <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // page_mem

// ==== tb/vaddr_translator_tb.sv ====
// self-checking bench for the virtual address translator
`timescale 1ns/1ps
`include "xlate_consts.svh"

module vaddr_translator_tb;
  logic clk, reset, regWrite, reqValid, reqReady, respValid, memReq, memAck, slow;
  logic [3:0] regSel;
  logic [31:0] regWdata, regRdata, reqVaddr, memData;
  logic [29:0] memAddr;
  xlate_pkg::xlate_resp_t resp;
  int bad_count, checks_done, k;
  logic en;
  logic [31:0] sbase, slen, lbase, llen, hbase, hlen;
  logic cv [16];
  logic [18:0] ct [16];
  logic [31:0] cp [16];
  logic [1:0] r;
  logic [20:0] n;

  vaddr_translator i_vaddr_translator (.clk(clk), .reset(reset), .regWrite(regWrite),
    .regSel(regSel), .regWdata(regWdata), .regRdata(regRdata), .reqValid(reqValid),
    .reqVaddr(reqVaddr), .reqReady(reqReady), .respValid(respValid), .resp(resp),
    .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData));
  page_mem i_mem (.clk(clk), .slow(slow), .memReq(memReq), .memAddr(memAddr),
    .memAck(memAck), .memData(memData));

  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] rdm(input logic [29:0] a);
    return i_mem.mem.exists(a) ? i_mem.mem[a] : 32'h0;
  endfunction

  function automatic xlate_pkg::xlate_resp_t model(input logic [31:0] va);
    xlate_pkg::xlate_resp_t e;
    logic [31:0] p, pv, s;
    logic [20:0] m;
    logic ok;
    e = '0;
    m = va[29:9];
    if (!en) begin
      e.paddr = va[29:0];
      return e;
    end
    if (cv[va[12:9]] && ct[va[12:9]] === va[31:13]) begin
      p = cp[va[12:9]];
    end else begin
      case (va[31:30])
        2'h2: ok = {1'b0, m} < slen[21:0];
        2'h0: ok = {1'b0, m} < llen[21:0];
        2'h1: ok = {1'b0, m} >= hlen[21:0];
        default: ok = 1'b0;
      endcase
      pv = (va[30] ? hbase : lbase) + {9'h0, m, 2'h0};
      if (va[31]) begin
        p = rdm(sbase[29:0] + {7'h0, m, 2'h0});
      end else begin
        s = rdm(sbase[29:0] + {7'h0, pv[29:9], 2'h0});
        ok = ok && pv[31:30] == 2'h2 && {1'b0, pv[29:9]} < slen[21:0] && s[31];
        p = rdm({s[20:0], pv[8:0]});
      end
      if (!ok) p = 32'h0;
      if (p[31]) begin
        cv[va[12:9]] = 1'b1;
        ct[va[12:9]] = va[31:13];
        cp[va[12:9]] = p;
      end
    end
    if (!p[31]) begin
      e.fault = 1'b1;
    end else begin
      e.rights = p[30:27];
      e.modify = p[26];
      e.paddr = {p[20:0], va[8:0]};
    end
    return e;
  endfunction

  // ---------------------------------------------------------------
  // compares, bus tasks, verdict
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] e);
    checks_done++;
    if (regRdata !== e) begin
      $display("CHECK FAILED t=%0t read %h want %h", $time, regRdata, e);
      bad_count++;
    end
  endtask

  task automatic chk_resp(input xlate_pkg::xlate_resp_t e);
    checks_done++;
    if (resp !== e) begin
      $display("CHECK FAILED t=%0t va %h resp %h want %h", $time, reqVaddr, resp, e);
      bad_count++;
    end
  endtask

  task automatic chk_ready(input logic e);
    checks_done++;
    if (reqReady !== e) begin
      $display("CHECK FAILED t=%0t ready %b want %b", $time, reqReady, e);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [3:0] sel, input logic [31:0] d);
    regWrite <= 1'b1;
    regSel <= sel;
    regWdata <= d;
    case (sel)
      `SEL_ENABLE: en = d[`ENABLE_BIT];
      `SEL_DROP_ONE: cv[d[12:9]] = 1'b0;
      `SEL_DROP_ALL: cv = '{default: 1'b0};
      `SEL_SYS_BASE: sbase = d;
      `SEL_SYS_LEN: slen = d;
      `SEL_LOW_BASE: lbase = d;
      `SEL_LOW_LEN: llen = d;
      `SEL_HIGH_BASE: hbase = d;
      `SEL_HIGH_LEN: hlen = d;
      default: ;
    endcase
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] sel, input logic [31:0] e);
    regSel <= sel;
    @(posedge clk);
    @(posedge clk);
    #1 chk_reg(e);
    @(posedge clk);
  endtask

  task automatic xl(input logic [31:0] va);
    xlate_pkg::xlate_resp_t e;
    int w;
    e = model(va);
    reqValid <= 1'b1;
    reqVaddr <= va;
    @(posedge clk);
    reqValid <= 1'b0;
    #1 chk_ready(1'b0);
    w = 0;
    do begin
      @(posedge clk);
      #1 w++;
    end while (respValid !== 1'b1 && w < 200);
    if (respValid !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    chk_resp(e);
    chk_ready(1'b1);
    @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    regWrite = 1'b0;
    regSel = 4'h0;
    regWdata = 32'h0;
    reqValid = 1'b0;
    reqVaddr = 32'h0;
    slow = 1'b0;
    bad_count = 0;
    checks_done = 0;
    {en, sbase, slen, lbase, llen, hbase, hlen} = '0;
    cv = '{default: 1'b0};
    void'($urandom(32'h3163));
    for (k = 0; k < 8192; k++) i_mem.mem[30'(k * 4)] = $urandom & 32'hffe0_003f;
    i_mem.mem[30'h1000] = 32'hfc1f_ffff;
    i_mem.mem[30'h1004] |= 32'h8000_0000;
    i_mem.mem[30'h1010] |= 32'h8000_0000;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(`SEL_SYS_LEN, 32'h0);
    rd(4'hf, 32'h0);
    for (k = 0; k < 4; k++) xl($urandom);
    wr(`SEL_ENABLE, 32'hffff_fffe);
    rd(`SEL_ENABLE, 32'h0);
    wr(`SEL_SYS_LEN, 32'hffff_ffff);
    rd(`SEL_SYS_LEN, 32'h003f_ffff);
    rd(`SEL_DROP_ALL, 32'h0);
    wr(`SEL_SYS_BASE, 32'h0000_1000);
    wr(`SEL_SYS_LEN, 32'd40);
    wr(`SEL_LOW_BASE, 32'h8000_0200);
    wr(`SEL_LOW_LEN, 32'd20);
    wr(`SEL_HIGH_BASE, 32'h7f80_0840);
    wr(`SEL_HIGH_LEN, 32'h001f_fff0);
    wr(`SEL_ENABLE, 32'h1);
    xl(32'h8000_0123);
    for (k = 0; k < 300; k++) begin
      slow <= k[3];
      r = 2'($urandom);
      n = r == 2'h1 ? 21'h1fffe8 + 21'($urandom_range(23, 0)) : 21'($urandom_range(47, 0));
      xl({r, n, 9'($urandom)});
      if (k % 16 == 15) wr(k[4] ? `SEL_DROP_ALL : `SEL_DROP_ONE, k[4] ? 32'h0 : $urandom);
    end
    xl(32'h8000_0a00);
    i_mem.mem[30'h1014] = 32'h8000_0015;
    xl(32'h8000_0a00);
    wr(`SEL_DROP_ONE, 32'h8000_0a00);
    xl(32'h8000_0a00);
    i_mem.mem[30'h1014] = 32'h0;
    wr(`SEL_DROP_ALL, 32'h0);
    xl(32'h8000_0a00);
    finish_test();
  end
endmodule // vaddr_translator_tb
